/* File: hw/dpw_cfg.svh */
/*
 Constants of the wiper command logic: register offsets, field positions,
 reset values and timing counts.
 Assumes a 40 MHz system clock and a 16-bit plain register port.
*/
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// Register offsets (byte addresses)
`define DPW_OFS_CMD 8'h00
`define DPW_OFS_WIPER 8'h04
`define DPW_OFS_STATUS 8'h08
`define DPW_OFS_READBACK 8'h0C
`define DPW_OFS_TOL 8'h10

// Command word layout
`define DPW_CMD_UNUSED_HI 15
`define DPW_CMD_UNUSED_LO 11
`define DPW_CMD_CODE_HI 10
`define DPW_CMD_CODE_LO 8
`define DPW_CMD_DATA_HI 7
`define DPW_CMD_DATA_LO 0

// Status bits
`define DPW_ST_BUSY 0
`define DPW_ST_SHUTDOWN 1
`define DPW_ST_TOP 2
`define DPW_ST_BOTTOM 3
`define DPW_ST_CMD_ERR 4
`define DPW_ST_RB_VALID 5

// Tolerance byte fields and their split view in the tolerance register
`define DPW_TOL_SIGN 7
`define DPW_TOL_INT_HI 6
`define DPW_TOL_INT_LO 3
`define DPW_TOL_FRAC_HI 2
`define DPW_TOL_FRAC_LO 0
`define DPW_TOLV_SIGN 12
`define DPW_TOLV_INT_LO 8

// Special wiper codes and reset values
`define DPW_CODE_BOTTOM 8'hFF
`define DPW_RST_WIPER 8'h00
`define DPW_RST_DATA 16'h0000
`define DPW_DEF_TOLERANCE 8'h00

// Timing
`define DPW_CLK_PERIOD_NS 25
`define DPW_RELOAD_TIME_NS 25000
`define DPW_RELOAD_CYCLES ((`DPW_RELOAD_TIME_NS) / (`DPW_CLK_PERIOD_NS))

`endif

/* File: hw/dpw_pkg.sv */
/*
 Types of the wiper command logic: controller states and command codes.
 Assumes dpw_cfg.svh supplies the numeric constants; state and command encodings are fixed here.
*/
`default_nettype none

package dpw_pkg;

   // Controller states, one-hot
   typedef enum logic [2:0] {
      ST_PRESET = 3'b001,
      ST_IDLE = 3'b010,
      ST_RELOAD = 3'b100
   } dpw_state_t;

   // Command field codes
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_STORE = 3'h1,
      CMD_WRITE = 3'h2,
      CMD_SHUTDOWN = 3'h3,
      CMD_RELOAD = 3'h4,
      CMD_READ_WIPER = 3'h5,
      CMD_READ_NVM = 3'h6,
      CMD_SPARE = 3'h7
   } dpw_cmd_t;

endpackage

`default_nettype wire

/* File: hw/dpw_nvm.sv */
/*
 Nonvolatile store: saved wiper byte and factory tolerance byte.
 Assumes the surrounding controller sequences writes; contents are not
 touched by the power-on reset, only by factory_load or a store.
*/
`include "dpw_cfg.svh"
`default_nettype none

module dpw_nvm #(
   parameter logic [7:0] TOLERANCE = `DPW_DEF_TOLERANCE
) (
   // Clock and enable
   input wire logic clk_sys,
   input wire logic ce,
   // Factory programming
   input wire logic factory_load,
   input wire logic [7:0] midscale,
   // Store port
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Read port
   input wire logic rd_sel,
   output logic [7:0] rd_data
);

   logic [7:0] mem_r [0:1];
   logic [7:0] mem_nxt [0:1];

   // Next contents; factory load wins over a user store
   always_comb begin
      mem_nxt[0] = mem_r[0];
      mem_nxt[1] = mem_r[1];
      if (factory_load) begin
         mem_nxt[0] = midscale;
         mem_nxt[1] = TOLERANCE;
      end else if (wr_en) begin
         mem_nxt[0] = wr_data;
      end
   end

   // No reset here: the store must survive a power-on preset
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         mem_r[0] <= mem_nxt[0];
         mem_r[1] <= mem_nxt[1];
      end
   end

   // Read is combinational; slot 1 holds the tolerance byte
   assign rd_data = rd_sel ? mem_r[1] : mem_r[0];

endmodule

`default_nettype wire

/* File: hw/dpw_tap_decode.sv */
/*
 Wiper code to tap decoder with top-scale, bottom-scale and shutdown.
 Assumes the caller registers the outputs.
*/
`include "dpw_cfg.svh"
`default_nettype none

module dpw_tap_decode #(
   parameter int RES_BITS = 7
) (
   // Code and mode
   input wire logic [7:0] code,
   input wire logic shutdown,
   // Switch controls
   output logic [RES_BITS-1:0] tap,
   output logic top_scale,
   output logic bottom_scale,
   output logic term_a_open
);

   localparam logic [7:0] TOP_CODE = 8'(1 << RES_BITS);

   // Shutdown parks the wiper on B; out-of-range codes clamp to top scale, except 8'hFF, which selects bottom scale
   always_comb begin
      tap = code[RES_BITS-1:0];
      top_scale = 1'b0;
      bottom_scale = 1'b0;
      term_a_open = 1'b0;
      if (shutdown) begin
         tap = '0;
         bottom_scale = 1'b1;
         term_a_open = 1'b1;
      end else if (code == `DPW_CODE_BOTTOM) begin
         tap = '0;
         bottom_scale = 1'b1;
      end else if (code >= TOP_CODE) begin
         tap = '1;
         top_scale = 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: hw/dpw_core.sv */
/*
 Command execution logic of a nonvolatile digital potentiometer: decodes
 16-bit command words, keeps the wiper position register, drives tap and
 scale controls, runs shutdown, reload and power-on preset.
 Assumes a plain register port on clk_sys with one-cycle strobes, and that
 the serial framing is done outside; factory_load programs the store once.
*/
// Decided for this implementation: strobed register access and the register addresses.
`include "dpw_cfg.svh"
`default_nettype none

module dpw_core #(
   parameter int RES_BITS = 7,
   parameter logic [7:0] TOLERANCE = `DPW_DEF_TOLERANCE,
   parameter int RELOAD_CYCLES = `DPW_RELOAD_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // Factory programming of the store
   input wire logic factory_load,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   // Resistor switch controls and busy flag
   output logic [RES_BITS-1:0] tap_sel,
   output logic top_scale_sel,
   output logic bottom_scale_sel,
   output logic term_a_open,
   output logic busy
);

   localparam int CNT_W = $clog2(RELOAD_CYCLES + 1);
   localparam logic [7:0] MIDSCALE = 8'(1 << (RES_BITS - 1));

   // Refuse values the decoder and counter cannot serve
   generate
      if (RES_BITS < 5 || RES_BITS > 7) begin : g_bad_res
         $error("RES_BITS must be 5, 6 or 7");
      end
      if (RELOAD_CYCLES < 1 || RELOAD_CYCLES > 4096) begin : g_bad_cnt
         $error("RELOAD_CYCLES must be 1 to 4096");
      end
   endgenerate

   // Control state
   dpw_pkg::dpw_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] wiper_position_register_r, wiper_position_register_nxt;
   logic shutdown_r, shutdown_nxt;
   logic cmd_err_r, cmd_err_nxt;
   logic rb_valid_r, rb_valid_nxt;
   logic [7:0] readback_r, readback_nxt;
   logic [15:0] last_cmd_r, last_cmd_nxt;

   // Store interface
   logic nvm_wr_en;
   logic nvm_rd_sel;
   logic [7:0] nvm_rd_data;

   // Decoded command fields
   logic cmd_wr;
   logic unused_zero;
   dpw_pkg::dpw_cmd_t cmd_code;
   logic [7:0] cmd_data;
   logic lowest_data_bit;
   logic memory_select_bit;
   logic [1:0] mem_addr;
   logic err_clear;

   // Decoder results
   logic [RES_BITS-1:0] dec_tap;
   logic dec_top, dec_bottom, dec_a_open;

   // Register port read data
   logic [15:0] rdata_nxt;
   logic [15:0] status_word;
   logic [15:0] tol_word;

   // Field split of a written command word
   assign cmd_wr = wr_stb && (addr == `DPW_OFS_CMD);
   assign unused_zero = (wdata[`DPW_CMD_UNUSED_HI:`DPW_CMD_UNUSED_LO] == 5'h00);
   assign cmd_code = dpw_pkg::dpw_cmd_t'(wdata[`DPW_CMD_CODE_HI:`DPW_CMD_CODE_LO]);
   assign cmd_data = wdata[`DPW_CMD_DATA_HI:`DPW_CMD_DATA_LO];
   assign lowest_data_bit = cmd_data[0];
   assign memory_select_bit = cmd_data[0];
   assign mem_addr = cmd_data[1:0];
   assign err_clear = wr_stb && (addr == `DPW_OFS_STATUS) && wdata[`DPW_ST_CMD_ERR];

   // Store write happens only for an accepted save command
   assign nvm_wr_en = (state_r == dpw_pkg::ST_IDLE) && cmd_wr && unused_zero
      && (cmd_code == dpw_pkg::CMD_STORE);
   // Tolerance slot is addressed by select bit with the upper address bit clear
   assign nvm_rd_sel = (state_r == dpw_pkg::ST_IDLE) && cmd_wr
      && (cmd_code == dpw_pkg::CMD_READ_NVM) && !mem_addr[1] && memory_select_bit;

   dpw_nvm #(
      .TOLERANCE(TOLERANCE)
   ) u_nvm (
      .clk_sys(clk_sys),
      .ce(ce),
      .factory_load(factory_load),
      .midscale(MIDSCALE),
      .wr_en(nvm_wr_en),
      .wr_data(wiper_position_register_r),
      .rd_sel(nvm_rd_sel),
      .rd_data(nvm_rd_data)
   );

   dpw_tap_decode #(
      .RES_BITS(RES_BITS)
   ) u_dec (
      .code(wiper_position_register_r),
      .shutdown(shutdown_r),
      .tap(dec_tap),
      .top_scale(dec_top),
      .bottom_scale(dec_bottom),
      .term_a_open(dec_a_open)
   );

   // Controller next state; commands are refused while a load is running
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      wiper_position_register_nxt = wiper_position_register_r;
      shutdown_nxt = shutdown_r;
      cmd_err_nxt = cmd_err_r;
      rb_valid_nxt = rb_valid_r;
      readback_nxt = readback_r;
      last_cmd_nxt = last_cmd_r;
      // Software clear first so a new error in the same cycle wins
      if (err_clear) begin
         cmd_err_nxt = 1'b0;
      end
      if (cmd_wr) begin
         last_cmd_nxt = wdata;
      end
      unique case (state_r)
         dpw_pkg::ST_PRESET: begin
            // First cycle after reset release takes the saved value
            wiper_position_register_nxt = nvm_rd_data;
            state_nxt = dpw_pkg::ST_IDLE;
            if (cmd_wr) begin
               cmd_err_nxt = 1'b1;
            end
         end
         dpw_pkg::ST_IDLE: begin
            if (cmd_wr && !unused_zero) begin
               cmd_err_nxt = 1'b1;
            end else if (cmd_wr) begin
               unique case (cmd_code)
                  dpw_pkg::CMD_WRITE: begin
                     wiper_position_register_nxt = cmd_data;
                  end
                  dpw_pkg::CMD_SHUTDOWN: begin
                     // Wiper register is kept; only the switches change
                     shutdown_nxt = lowest_data_bit;
                  end
                  dpw_pkg::CMD_RELOAD: begin
                     cnt_nxt = CNT_W'(RELOAD_CYCLES - 1);
                     state_nxt = dpw_pkg::ST_RELOAD;
                  end
                  dpw_pkg::CMD_READ_WIPER: begin
                     readback_nxt = wiper_position_register_r;
                     rb_valid_nxt = 1'b1;
                  end
                  dpw_pkg::CMD_READ_NVM: begin
                     // Address 1x has no content and reads as zero
                     readback_nxt = mem_addr[1] ? 8'h00 : nvm_rd_data;
                     rb_valid_nxt = 1'b1;
                  end
                  dpw_pkg::CMD_SPARE: begin
                     cmd_err_nxt = 1'b1;
                  end
                  dpw_pkg::CMD_NOP, dpw_pkg::CMD_STORE: begin
                     // Store is done by the write port of the store itself
                     state_nxt = state_r;
                  end
               endcase
            end
         end
         dpw_pkg::ST_RELOAD: begin
            if (cmd_wr) begin
               cmd_err_nxt = 1'b1;
            end
            if (cnt_r == '0) begin
               wiper_position_register_nxt = nvm_rd_data;
               state_nxt = dpw_pkg::ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         default: begin
            state_nxt = dpw_pkg::ST_PRESET;
         end
      endcase
   end

   // Controller registers; reset is the power-on preset request
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= dpw_pkg::ST_PRESET;
         cnt_r <= '0;
         wiper_position_register_r <= `DPW_RST_WIPER;
         shutdown_r <= 1'b0;
         cmd_err_r <= 1'b0;
         rb_valid_r <= 1'b0;
         readback_r <= 8'h00;
         last_cmd_r <= `DPW_RST_DATA;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wiper_position_register_r <= wiper_position_register_nxt;
         shutdown_r <= shutdown_nxt;
         cmd_err_r <= cmd_err_nxt;
         rb_valid_r <= rb_valid_nxt;
         readback_r <= readback_nxt;
         last_cmd_r <= last_cmd_nxt;
      end
   end

   // Status and tolerance views
   always_comb begin
      status_word = 16'h0000;
      status_word[`DPW_ST_BUSY] = (state_r != dpw_pkg::ST_IDLE);
      status_word[`DPW_ST_SHUTDOWN] = shutdown_r;
      status_word[`DPW_ST_TOP] = top_scale_sel;
      status_word[`DPW_ST_BOTTOM] = bottom_scale_sel;
      status_word[`DPW_ST_CMD_ERR] = cmd_err_r;
      status_word[`DPW_ST_RB_VALID] = rb_valid_r;
      // Split the sign-magnitude byte so software need not shift it
      tol_word = 16'h0000;
      tol_word[`DPW_TOLV_SIGN] = readback_r[`DPW_TOL_SIGN];
      tol_word[`DPW_TOLV_INT_LO +: 4] = readback_r[`DPW_TOL_INT_HI:`DPW_TOL_INT_LO];
      tol_word[2:0] = readback_r[`DPW_TOL_FRAC_HI:`DPW_TOL_FRAC_LO];
   end

   // Read data mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 16'h0000;
      if (rd_stb) begin
         unique case (addr)
            `DPW_OFS_CMD: rdata_nxt = last_cmd_r;
            `DPW_OFS_WIPER: rdata_nxt = {8'h00, wiper_position_register_r};
            `DPW_OFS_STATUS: rdata_nxt = status_word;
            `DPW_OFS_READBACK: rdata_nxt = {8'h00, readback_r};
            `DPW_OFS_TOL: rdata_nxt = tol_word;
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= rdata_nxt;
      end
   end

   // Switch controls are registered so they never glitch on decode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tap_sel <= '0;
         top_scale_sel <= 1'b0;
         bottom_scale_sel <= 1'b0;
         term_a_open <= 1'b0;
      end else if (ce) begin
         tap_sel <= dec_tap;
         top_scale_sel <= dec_top;
         bottom_scale_sel <= dec_bottom;
         term_a_open <= dec_a_open;
      end
   end

   assign busy = (state_r != dpw_pkg::ST_IDLE);

endmodule

`default_nettype wire

/* File: bench/dpw_core_assertions.sv */
/*
 Port checker of the wiper command logic: decode, shutdown, reload, preset.
 Assumes ce stays high while commands are under test.
*/
`default_nettype none

module dpw_core_assertions #(
   parameter int RES_BITS = 7,
   parameter int RELOAD_CYCLES = 1000
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // Command port
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   // Switch controls and busy flag
   input wire logic [RES_BITS-1:0] tap_sel,
   input wire logic top_scale_sel,
   input wire logic bottom_scale_sel,
   input wire logic term_a_open,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [8:0] TOP_CODE = 9'(1 << RES_BITS);
   logic [12:0] rl_cnt_r;
   logic [12:0] rl_cnt_nxt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   // Reload length is counted here, too long for a repetition
   always_comb begin
      rl_cnt_nxt = rl_cnt_r;
      if (ce && wr_stb && addr == 8'h00 && wdata[15:8] == 8'h04 && !busy) rl_cnt_nxt = 13'h0001;
      else if (ce && rl_cnt_r != 13'h0000 && busy) rl_cnt_nxt = rl_cnt_r + 13'h0001;
      else if (ce) rl_cnt_nxt = 13'h0000;
   end

   // Counter register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) rl_cnt_r <= 13'h0000;
      else rl_cnt_r <= rl_cnt_nxt;
   end

   // Accepted command, then one cycle with no new command
   sequence s_cmd(hi, ok);
      ce && wr_stb && addr == 8'h00 && wdata[15:8] == hi && !busy && ok;
   endsequence
   sequence s_still(x);
      ce && !wr_stb && x;
   endsequence

   a_tap_normal:
   assert property (s_cmd(8'h02, {1'b0, wdata[7:0]} < TOP_CODE) ##1 s_still(!term_a_open)
      |=> tap_sel == $past(wdata[RES_BITS-1:0], 2) && !top_scale_sel && !bottom_scale_sel)
      else $error("tap does not follow code");
   a_top_scale:
   assert property (s_cmd(8'h02, wdata[7:0] != 8'hFF && {1'b0, wdata[7:0]} >= TOP_CODE)
      ##1 s_still(!term_a_open) |=> top_scale_sel && (&tap_sel) && !bottom_scale_sel)
      else $error("top scale not selected");
   a_bottom_scale:
   assert property (s_cmd(8'h02, wdata[7:0] == 8'hFF) ##1 s_still(!term_a_open)
      |=> bottom_scale_sel && tap_sel == '0 && !top_scale_sel)
      else $error("bottom scale not selected");
   a_shutdown_on:
   assert property (s_cmd(8'h03, wdata[0]) ##1 s_still(1'b1)
      |=> term_a_open && bottom_scale_sel && tap_sel == '0)
      else $error("shutdown not entered");
   a_shutdown_off:
   assert property (s_cmd(8'h03, !wdata[0]) ##1 s_still(1'b1) |=> !term_a_open)
      else $error("shutdown not left");
   a_refused_word:
   assert property (s_cmd(wdata[15:8], wdata[15:11] != 5'h00) ##1 s_still(1'b1)
      |=> $stable(tap_sel) && $stable(term_a_open) && $stable(top_scale_sel))
      else $error("bad word changed the wiper");
   a_reload_len:
   assert property (rl_cnt_r != 13'h0000 |-> (busy ? rl_cnt_r <= 13'(RELOAD_CYCLES)
      : rl_cnt_r == 13'(RELOAD_CYCLES + 1)))
      else $error("reload busy length wrong");
   a_preset_one:
   assert property ($rose(arst_n) |-> busy ##1 !busy)
      else $error("preset not one cycle");
endmodule

bind dpw_core dpw_core_assertions #(.RES_BITS(RES_BITS), .RELOAD_CYCLES(RELOAD_CYCLES)) u_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .tap_sel(tap_sel), .top_scale_sel(top_scale_sel), .bottom_scale_sel(bottom_scale_sel),
   .term_a_open(term_a_open), .busy(busy));

`default_nettype wire

/* File: bench/dpw_host_model.sv */
/*
 Command master model: one-cycle strobes on the register port.
 Assumes the slave never stalls; the testbench calls its tasks.
*/
`include "dpw_cfg.svh"
`default_nettype none

module dpw_host_model (
   // Clock and read data
   input wire logic clk_sys,
   input wire logic [15:0] rdata,
   // Requests
   output var logic [7:0] addr,
   output var logic [15:0] wdata,
   output var logic wr_stb,
   output var logic rd_stb
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // Released qualifiers are inverted so stale values are never relied on
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask

   // Whole command word: zero top bits, code, data
   task automatic bus_cmd(input logic [2:0] code, input logic [7:0] data);
      bus_wr(`DPW_OFS_CMD, {5'h00, code, data});
   endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
/*
 Testbench of the wiper command logic: commands via the host model.
 Assumes the design, checker and host model are compiled first.
*/
`include "dpw_cfg.svh"
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic factory_load = 1'b1;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [15:0] rdata;
   logic [6:0] tap_sel;
   logic top_scale_sel;
   logic bottom_scale_sel;
   logic term_a_open;
   logic busy;
   logic [15:0] rd_v;
   logic [7:0] codes [6] = '{8'h00, 8'h45, 8'h7F, 8'h80, 8'h9A, 8'hFF};
   int num_errors = 0;
   int num_checks = 0;
   int n;

   // Short reload keeps the run brief; tolerance is +10.25 percent
   dpw_core #(.RES_BITS(7), .TOLERANCE(8'h52), .RELOAD_CYCLES(4)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .factory_load(factory_load),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .tap_sel(tap_sel), .top_scale_sel(top_scale_sel), .bottom_scale_sel(bottom_scale_sel),
      .term_a_open(term_a_open), .busy(busy));
   dpw_host_model host (.clk_sys(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb));

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pins(input logic [6:0] t, input logic top, input logic bot, input logic aop);
      check({6'h00, top_scale_sel, bottom_scale_sel, term_a_open, tap_sel}, {6'h00, top, bot, aop, t});
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      host.bus_rd(a, rd_v);
      check(rd_v, exp);
   endtask
   // Decoded outputs settle two edges after the command
   task automatic cmd(input logic [2:0] code, input logic [7:0] data);
      host.bus_cmd(code, data);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic reset_dut();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      reset_dut();
      factory_load <= 1'b0;
      pins(7'h40, 1'b0, 1'b0, 1'b0);
      rd(`DPW_OFS_WIPER, 16'h0040);
      $display("test preset done");
      foreach (codes[i]) begin
         cmd(3'h2, codes[i]);
         if (codes[i] == 8'hFF) pins(7'h00, 1'b0, 1'b1, 1'b0);
         else if (codes[i] >= 8'h80) pins(7'h7F, 1'b1, 1'b0, 1'b0);
         else pins(codes[i][6:0], 1'b0, 1'b0, 1'b0);
         rd(`DPW_OFS_WIPER, {8'h00, codes[i]});
      end
      host.bus_wr(`DPW_OFS_CMD, 16'h8245);
      rd(`DPW_OFS_WIPER, 16'h00FF);
      rd(`DPW_OFS_CMD, 16'h8245);
      host.bus_rd(`DPW_OFS_STATUS, rd_v);
      check(rd_v & 16'h0010, 16'h0010);
      host.bus_wr(`DPW_OFS_STATUS, 16'h0010);
      host.bus_rd(`DPW_OFS_STATUS, rd_v);
      check(rd_v & 16'h0010, 16'h0000);
      // The spare code is refused like a malformed word
      host.bus_cmd(3'h7, 8'h00);
      host.bus_rd(`DPW_OFS_STATUS, rd_v);
      check(rd_v & 16'h0010, 16'h0010);
      host.bus_wr(`DPW_OFS_STATUS, 16'h0010);
      rd(8'h14, 16'h0000);
      $display("test decode done");
      cmd(3'h2, 8'h33);
      cmd(3'h1, 8'h00);
      cmd(3'h2, 8'h10);
      host.bus_cmd(3'h4, 8'h00);
      #1;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(16'(n), 16'h0004);
      rd(`DPW_OFS_WIPER, 16'h0033);
      $display("test store reload done");
      cmd(3'h3, 8'h01);
      pins(7'h00, 1'b0, 1'b1, 1'b1);
      rd(`DPW_OFS_WIPER, 16'h0033);
      cmd(3'h5, 8'h00);
      rd(`DPW_OFS_READBACK, 16'h0033);
      cmd(3'h3, 8'h00);
      pins(7'h33, 1'b0, 1'b0, 1'b0);
      $display("test shutdown done");
      cmd(3'h6, 8'h01);
      rd(`DPW_OFS_READBACK, 16'h0052);
      rd(`DPW_OFS_TOL, 16'h0A02);
      cmd(3'h6, 8'h00);
      rd(`DPW_OFS_READBACK, 16'h0033);
      cmd(3'h6, 8'h02);
      rd(`DPW_OFS_READBACK, 16'h0000);
      $display("test readback done");
      cmd(3'h2, 8'h05);
      reset_dut();
      rd(`DPW_OFS_WIPER, 16'h0033);
      pins(7'h33, 1'b0, 1'b0, 1'b0);
      $display("test second reset done");
      print_verdict();
   end

   // Watchdog: tests need under 10 us, so 100 us means a hang
   initial begin
      #100us;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule

`default_nettype wire
